// *** hcsr_pkg.sv ***
// Package for the host command/status register block
package hcsr_pkg;
    // ==========================================================
    // Register map
    localparam logic [7:0] CMD_STATUS_OFS = 8'h08;
    localparam int SOC_LSB = 16;
    localparam int SOC_W = 2;
    localparam int OWN_REQ_BIT = 3;
    localparam int BULK_FILL_BIT = 2;
    localparam int CTRL_FILL_BIT = 1;
    localparam int SOFT_RST_BIT = 0;
    localparam logic [31:0] CMD_STATUS_RST = 32'h0000_0000;
    // ==========================================================
    // Timing
    localparam int CLK_HZ = 20_000_000;
    localparam int SRST_MAX_NS = 10_000;
    localparam int SRST_MAX_CYC = SRST_MAX_NS / (1_000_000_000 / CLK_HZ);
    localparam int SRST_DEF_CYC = 16;
    // ==========================================================
    // Soft reset sequencer states
    typedef enum logic [2:0] {
        HCSR_IDLE = 3'b001,
        HCSR_RUN = 3'b010,
        HCSR_DONE = 3'b100
    } hcsr_state_t;
endpackage : hcsr_pkg

// *** hcsr_soft_reset.sv ***
// Soft reset sequencer: timed pulse run for a controller soft reset
`timescale 1ns/1ns
module hcsr_soft_reset
    import hcsr_pkg::*;
#(
    parameter int RESET_CYCLES = SRST_DEF_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Control
    input wire logic start,
    output logic busy,
    output logic done
);
    // ==========================================================
    // Counter and state
    localparam int CW = $clog2(SRST_MAX_CYC + 1);
    hcsr_state_t state_q, state_d;
    logic [CW-1:0] cnt_q, cnt_d;
    localparam logic [CW-1:0] LAST = CW'(RESET_CYCLES - 1);

    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        case (state_q)
            HCSR_IDLE: begin
                cnt_d = '0;
                if (start) begin
                    state_d = HCSR_RUN;
                end
            end
            HCSR_RUN: begin
                cnt_d = cnt_q + CW'(1);
                if (cnt_q >= LAST) begin
                    state_d = HCSR_DONE;
                end
            end
            HCSR_DONE: state_d = HCSR_IDLE;
            default: state_d = HCSR_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            state_q <= HCSR_IDLE;
            cnt_q <= '0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
        end
    end

    assign busy = (state_q == HCSR_RUN);
    assign done = (state_q == HCSR_DONE);
endmodule : hcsr_soft_reset

// *** hcsr_top.sv ***
// Host controller command/status register with soft reset sequencing
`timescale 1ns/1ns
module hcsr_top
    import hcsr_pkg::*;
#(
    parameter int RESET_CYCLES = SRST_DEF_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Register access port
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_wdata,
    output logic [31:0] reg_rdata,
    // Frame and list engine events
    input wire logic periodic_overrun,
    input wire logic bulk_head,
    input wire logic bulk_descriptor_found,
    input wire logic control_head,
    input wire logic control_descriptor_found,
    input wire logic ownership_done,
    // Decisions to the list engine
    output logic bulk_process,
    output logic control_process,
    // Status to interrupt logic
    output logic scheduling_overrun_set,
    output logic ownership_changed_flag,
    // Soft reset effects
    output logic suspend_enter,
    output logic op_regs_reset,
    output logic host_bus_block
);
    // ==========================================================
    // Helper functions

    // Write-to-set strobe for one bit of the register
    function automatic logic set_strobe(
        input logic wr_hit_i,
        input logic [31:0] data_i,
        input int pos_i
    );
        set_strobe = wr_hit_i && data_i[pos_i];
    endfunction : set_strobe

    // Sticky bit update: any set beats a clear in the same cycle
    function automatic logic flag_next(
        input logic cur_i,
        input logic set_i,
        input logic clr_i
    );
        if (set_i) begin
            flag_next = 1'b1;
        end else if (clr_i) begin
            flag_next = 1'b0;
        end else begin
            flag_next = cur_i;
        end
    endfunction : flag_next

    // Read word; reserved positions show their reset value
    function automatic logic [31:0] pack_word(
        input logic [SOC_W-1:0] cnt_i,
        input logic own_i,
        input logic bulk_i,
        input logic ctrl_i,
        input logic rst_i
    );
        pack_word = CMD_STATUS_RST;
        pack_word[SOC_LSB +: SOC_W] = cnt_i;
        pack_word[OWN_REQ_BIT] = own_i;
        pack_word[BULK_FILL_BIT] = bulk_i;
        pack_word[CTRL_FILL_BIT] = ctrl_i;
        pack_word[SOFT_RST_BIT] = rst_i;
    endfunction : pack_word

    // ==========================================================
    // Register state
    logic [SOC_W-1:0] ovr_cnt_q;
    logic [SOC_W-1:0] ovr_cnt_d;
    logic own_req_q;
    logic own_req_d;
    logic bulk_fill_q;
    logic bulk_fill_d;
    logic ctrl_fill_q;
    logic ctrl_fill_d;
    logic soft_rst_q;
    logic soft_rst_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;

    // ==========================================================
    // Address decode and write-to-set strobes
    wire hit = (reg_addr == CMD_STATUS_OFS);
    wire wr_hit = reg_wr && hit;
    wire rd_hit = reg_rd && hit;
    // Reserved positions are ignored on write
    wire set_own = set_strobe(wr_hit, reg_wdata, OWN_REQ_BIT);
    wire set_bulk = set_strobe(wr_hit, reg_wdata, BULK_FILL_BIT);
    wire set_ctrl = set_strobe(wr_hit, reg_wdata, CTRL_FILL_BIT);
    wire set_rst = set_strobe(wr_hit, reg_wdata, SOFT_RST_BIT);

    // ==========================================================
    // Soft reset sequencer
    wire rst_busy;
    wire rst_done;
    // A request while one runs is dropped, never restarted
    wire rst_start = set_rst && !soft_rst_q;

    hcsr_soft_reset #(
        .RESET_CYCLES(RESET_CYCLES)
    ) hcsr_soft_reset_i (
        .clk(clk),
        .srst(srst),
        .start(rst_start),
        .busy(rst_busy),
        .done(rst_done)
    );

    // ==========================================================
    // List head decisions: sample filled bit, none in soft reset
    wire bulk_go = bulk_head && bulk_fill_q && !soft_rst_q;
    wire ctrl_go = control_head && ctrl_fill_q && !soft_rst_q;
    // A found descriptor keeps list processing alive
    wire bulk_set_any = set_bulk || bulk_descriptor_found;
    wire ctrl_set_any = set_ctrl || control_descriptor_found;

    // ==========================================================
    // Next-state logic; soft reset start clears and beats any set

    always_comb begin
        ovr_cnt_d = ovr_cnt_q;
        if (periodic_overrun) begin
            // Counts even while the interrupt flag is still set
            ovr_cnt_d = ovr_cnt_q + SOC_W'(1);
        end
        if (rst_start) begin
            ovr_cnt_d = '0;
        end
    end

    always_comb begin
        own_req_d = flag_next(own_req_q, set_own, ownership_done);
        if (rst_start) begin
            own_req_d = 1'b0;
        end
    end

    always_comb begin
        bulk_fill_d = flag_next(bulk_fill_q, bulk_set_any, bulk_go);
        if (rst_start) begin
            bulk_fill_d = 1'b0;
        end
    end

    always_comb begin
        ctrl_fill_d = flag_next(ctrl_fill_q, ctrl_set_any, ctrl_go);
        if (rst_start) begin
            ctrl_fill_d = 1'b0;
        end
    end

    // Done clears the bit; a late request in that cycle is refused
    always_comb begin
        soft_rst_d = soft_rst_q;
        if (set_rst) begin
            soft_rst_d = 1'b1;
        end
        if (rst_done) begin
            soft_rst_d = 1'b0;
        end
    end

    // ==========================================================
    // Read path: registered, unmapped addresses read zero
    wire [31:0] rd_word = pack_word(ovr_cnt_q, own_req_q, bulk_fill_q,
                                    ctrl_fill_q, soft_rst_q);

    always_comb begin
        rdata_d = rdata_q;
        if (reg_rd) begin
            rdata_d = rd_hit ? rd_word : '0;
        end
    end

    // ==========================================================
    // Flip-flops

    always_ff @(posedge clk) begin
        if (srst) begin
            ovr_cnt_q <= CMD_STATUS_RST[SOC_LSB +: SOC_W];
        end else begin
            ovr_cnt_q <= ovr_cnt_d;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            own_req_q <= CMD_STATUS_RST[OWN_REQ_BIT];
        end else begin
            own_req_q <= own_req_d;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            bulk_fill_q <= CMD_STATUS_RST[BULK_FILL_BIT];
        end else begin
            bulk_fill_q <= bulk_fill_d;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            ctrl_fill_q <= CMD_STATUS_RST[CTRL_FILL_BIT];
        end else begin
            ctrl_fill_q <= ctrl_fill_d;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            soft_rst_q <= CMD_STATUS_RST[SOFT_RST_BIT];
        end else begin
            soft_rst_q <= soft_rst_d;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            rdata_q <= 32'h0000_0000;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    // ==========================================================
    // Outputs
    assign reg_rdata = rdata_q;
    assign bulk_process = bulk_go;
    assign control_process = ctrl_go;
    assign scheduling_overrun_set = periodic_overrun;
    assign ownership_changed_flag = own_req_q;
    assign suspend_enter = rst_start;
    assign op_regs_reset = rst_start;
    // Bus mastering and the list head decisions are held off; hub and ports see nothing
    assign host_bus_block = soft_rst_q || rst_busy;
endmodule : hcsr_top

// *** hcsr_top_checker.sv ***
// Checker for the command/status register block
`timescale 1ns/1ns
module hcsr_top_checker
    import hcsr_pkg::*;
#(
    parameter int RESET_CYCLES = SRST_DEF_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Register access
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [31:0] reg_wdata,
    // Engine events
    input wire logic periodic_overrun,
    input wire logic bulk_head,
    input wire logic bulk_descriptor_found,
    input wire logic control_head,
    input wire logic control_descriptor_found,
    input wire logic ownership_done,
    // Outputs
    input wire logic bulk_process,
    input wire logic control_process,
    input wire logic scheduling_overrun_set,
    input wire logic ownership_changed_flag,
    input wire logic suspend_enter,
    input wire logic op_regs_reset,
    input wire logic host_bus_block
);
    // ==========================================================
    // Properties
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    wire wr8 = reg_wr && reg_addr == CMD_STATUS_OFS;
    // Soft reset request that the block will accept
    wire rst_req = wr8 && reg_wdata[SOFT_RST_BIT] && !host_bus_block;
    // Filled-bit models kept from the rules, not from the design
    logic bulk_m_q;
    logic ctrl_m_q;
    always_ff @(posedge clk) begin
        if (srst || rst_req) begin
            bulk_m_q <= 1'b0;
        end else if ((wr8 && reg_wdata[BULK_FILL_BIT]) ||
                     bulk_descriptor_found) begin
            bulk_m_q <= 1'b1;
        end else if (bulk_process) begin
            bulk_m_q <= 1'b0;
        end
    end
    always_ff @(posedge clk) begin
        if (srst || rst_req) begin
            ctrl_m_q <= 1'b0;
        end else if ((wr8 && reg_wdata[CTRL_FILL_BIT]) ||
                     control_descriptor_found) begin
            ctrl_m_q <= 1'b1;
        end else if (control_process) begin
            ctrl_m_q <= 1'b0;
        end
    end
    a_overrun_copy: assert property (
        scheduling_overrun_set == periodic_overrun) else $error("overrun");
    a_own_set: assert property (
        wr8 && reg_wdata[OWN_REQ_BIT] && !reg_wdata[SOFT_RST_BIT] &&
        !host_bus_block |=> ownership_changed_flag)
        else $error("own flag not set");
    a_bulk_model: assert property (
        bulk_head && !host_bus_block |-> bulk_process == bulk_m_q)
        else $error("bulk decision differs from filled bit");
    a_ctrl_model: assert property (
        control_head && !host_bus_block |-> control_process == ctrl_m_q)
        else $error("control decision differs from filled bit");
    a_ctrl_clear: assert property (
        control_process && !control_descriptor_found && !wr8 ##1
        control_head |-> !control_process) else $error("ctrl not cleared");
    a_ctrl_refill: assert property (
        control_descriptor_found && !host_bus_block && !wr8 ##1
        control_head && !host_bus_block |-> control_process)
        else $error("ctrl not refilled");
    a_own_clear: assert property (
        ownership_done && !wr8 && !host_bus_block
        |=> !ownership_changed_flag) else $error("own flag kept");
    a_bulk_skip: assert property (
        bulk_process |-> bulk_head) else $error("bulk without head");
    a_bulk_clear: assert property (
        bulk_process && !bulk_descriptor_found && !wr8 ##1 bulk_head
        |-> !bulk_process) else $error("bulk bit not cleared");
    a_bulk_refill: assert property (
        bulk_descriptor_found && !host_bus_block && !wr8 ##1 bulk_head &&
        !host_bus_block |-> bulk_process) else $error("bulk not refilled");
    a_ctrl_skip: assert property (
        control_process |-> control_head) else $error("ctrl without head");
    a_sreset_start: assert property (
        rst_req |-> suspend_enter &&
        op_regs_reset ##1 host_bus_block) else $error("soft reset start");
    a_sreset_bound: assert property (
        $rose(host_bus_block) |-> ##[1:200] !host_bus_block)
        else $error("soft reset too long");
    c_overrun: cover property (periodic_overrun);
    c_bulk: cover property (bulk_process && bulk_descriptor_found);
    c_ctrl: cover property (control_process && control_descriptor_found);
    c_sreset: cover property ($fell(host_bus_block));
endmodule : hcsr_top_checker

bind hcsr_top hcsr_top_checker #(.RESET_CYCLES(RESET_CYCLES)) chk_i (.*);

// *** hcsr_top_tb.sv ***
// Testbench for the command/status register block
`timescale 1ns/1ns
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin n_errors++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, a, b); end end
module hcsr_top_tb;
    // ==========================================================
    // Signals
    logic clk = 0, srst = 1, reg_wr = 0, reg_rd = 0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0, reg_rdata;
    logic [5:0] evv = 6'h00;
    logic bp, cp, pb, pc, ocf, se, orr, hbb, sos, ps, po, pso;
    int n_errors = 0, comparisons = 0, i;
    hcsr_top #(.RESET_CYCLES(4)) hcsr_top_i (.clk(clk), .srst(srst),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .periodic_overrun(evv[0]), .bulk_head(evv[1]),
        .bulk_descriptor_found(evv[2]), .control_head(evv[3]),
        .control_descriptor_found(evv[4]), .ownership_done(evv[5]),
        .bulk_process(bp), .control_process(cp),
        .scheduling_overrun_set(sos), .ownership_changed_flag(ocf),
        .suspend_enter(se), .op_regs_reset(orr), .host_bus_block(hbb));
    initial begin
        forever #25 clk = ~clk;
    end
    // ==========================================================
    // Access tasks
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(negedge clk) reg_addr = a;
        reg_wdata = d;
        reg_wr = 1;
        #1 ps = se;
        po = orr;
        @(negedge clk) reg_wr = 0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(negedge clk) reg_addr = a;
        reg_rd = 1;
        @(negedge clk) reg_rd = 0;
        `CHK(reg_rdata, e)
    endtask : rd
    // Sample decisions 1 ns into the pulse, before the edge acts on them
    task automatic ev(input logic [5:0] e);
        @(negedge clk) evv = e;
        #1 pb = bp;
        pc = cp;
        pso = sos;
        @(negedge clk) evv = 6'h00;
    endtask : ev
    task automatic conclude;
        $display("errors=%0d comparisons=%0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : conclude
    // ==========================================================
    // Tests
    initial begin
        #100000 n_errors++;
        conclude();
    end
    initial begin
        repeat (4) @(negedge clk);
        srst = 0;
        rd(8'h08, 32'h0);
        for (i = 0; i < 5; i++) ev(6'h01);
        `CHK(pso, 1'b1)
        rd(8'h08, 32'h0001_0000);
        wr(8'h08, 32'h6);
        wr(8'h08, 32'h0);
        wr(8'h04, 32'h8);
        rd(8'h08, 32'h0001_0006);
        rd(8'h04, 32'h0);
        wr(8'h08, 32'h8);
        `CHK(ocf, 1'b1)
        `CHK(ps, 1'b0)
        ev(6'h20);
        `CHK(pso, 1'b0)
        `CHK(ocf, 1'b0)
        ev(6'h02);
        `CHK(pb, 1'b1)
        rd(8'h08, 32'h0001_0002);
        ev(6'h02);
        `CHK(pb, 1'b0)
        wr(8'h08, 32'h4);
        ev(6'h06);
        rd(8'h08, 32'h0001_0006);
        ev(6'h08);
        `CHK(pc, 1'b1)
        ev(6'h08);
        `CHK(pc, 1'b0)
        wr(8'h08, 32'h2);
        ev(6'h18);
        rd(8'h08, 32'h0001_0006);
        wr(8'h08, 32'h1);
        `CHK(ps, 1'b1)
        `CHK(po, 1'b1)
        `CHK(hbb, 1'b1)
        rd(8'h08, 32'h1);
        for (i = 0; i < 200 && hbb; i++) @(negedge clk);
        `CHK(hbb, 1'b0)
        rd(8'h08, 32'h0);
        conclude();
    end
endmodule : hcsr_top_tb
